// File: ssrp_pkg.sv
// ssrp_pkg: shared constants and types of the serial register port
package ssrp_pkg;

    // -------------------------------------------------------------------------
    // instruction geometry
    // -------------------------------------------------------------------------
    localparam int          INSTR_W   = 56;
    localparam int          HDR_W     = 24;
    localparam int          DATA_W    = 32;
    localparam int          CNT_W     = 6;
    localparam int          CMD_POS   = 55;
    localparam int          CHAN_HI   = 54;
    localparam int          CHAN_LO   = 53;
    localparam int          DEV_HI    = 52;
    localparam int          DEV_LO    = 48;
    localparam int          REG_HI    = 47;
    localparam int          REG_LO    = 32;
    localparam logic [5:0]  LAST_BIT  = 6'h37;
    localparam logic [5:0]  HDR_END   = 6'h18;
    localparam logic [4:0]  HDR_TOP   = 5'h17;

    // -------------------------------------------------------------------------
    // field encodings
    // -------------------------------------------------------------------------
    localparam logic        CMD_READ  = 1'h0;
    localparam logic        CMD_WRITE = 1'h1;
    localparam logic [1:0]  CHAN_0    = 2'h0;
    localparam logic [1:0]  CHAN_1    = 2'h1;

    // output timing control bit, reached at its own address on channel 0
    localparam logic [1:0]  FAST_CHAN = 2'h0;
    localparam logic [4:0]  FAST_DEV  = 5'h1E;
    localparam logic [15:0] FAST_REG  = 16'hFF00;
    localparam int          FAST_BIT  = 0;
    localparam logic        FAST_RST  = 1'h0;

    // synchroniser reset image: {sck, mosi, select_n}
    localparam logic [2:0]  PIN_RST   = 3'h1;

    // -------------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  chan;
        logic [4:0]  dev;
        logic [15:0] num;
        logic [31:0] data;
    } ssrp_req_t;

    typedef enum logic {SSRP_IDLE, SSRP_ACTIVE} ssrp_state_t;

endpackage : ssrp_pkg

// File: ssrp_sync.sv
// ssrp_sync: two-flop synchroniser for the port pins
`timescale 1ns/10ps
module ssrp_sync #(
    parameter int             WIDTH     = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // pins and synchronised copy
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // -------------------------------------------------------------------------
    // two stages; the first is read only by the second
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RESET_VAL;
            dout   <= RESET_VAL;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule : ssrp_sync

// File: ssrp_tx_mux.sv
// ssrp_tx_mux: selects the outgoing serial bit of the current instruction
`timescale 1ns/10ps
module ssrp_tx_mux
    import ssrp_pkg::*;
(
    // echo of the previous instruction
    input  wire logic [HDR_W-1:0]  hdr,
    input  wire logic [DATA_W-1:0] dataHold,
    // command of the instruction now shifting
    input  wire logic              curCmd,
    // bit position, 0 = bit 55
    input  wire logic [CNT_W-1:0]  idx,
    // selected bit
    output logic                   txBit
);

    logic [DATA_W-1:0]  dataSel;
    logic [INSTR_W-1:0] word;

    // -------------------------------------------------------------------------
    // data field: write data after a write, fetched data between reads,
    // zeros when a write follows a read
    // -------------------------------------------------------------------------
    always_comb begin
        if (hdr[HDR_W-1] == CMD_WRITE) begin
            dataSel = dataHold;
        end else if (curCmd == CMD_WRITE) begin
            dataSel = '0;
        end else begin
            dataSel = dataHold;
        end
        word  = {hdr, dataSel};
        txBit = word[LAST_BIT - idx];
    end

endmodule : ssrp_tx_mux

// File: ssrp_core.sv
// ssrp_core: serial register port, shift logic, fetch and output timing
//
// Behaviour
// - select low enables the port; high ignores the bus and floats data out.
// - data in is sampled on every serial clock rising edge, either mode.
// - each instruction is 56 bits: command, 23 address bits, 32 data bits.
// - bits travel most significant first, bit 55 to bit 0, both directions.
// - bit 55 command, 54:53 channel, 52:48 group, 47:32 register, 31:0 data.
// - channel 00 and 01 are valid; 10 and 11 select nothing.
// - a write stores its data; read data bits are clocked in and ignored.
// - reads are pipelined; fetched data goes out during the following read.
// - back-to-back reads each carry a new address, without limit.
// - command and address positions echo the previous instruction.
// - after a write, the data field echoes that write's data.
// - a write following a read shows zeros in the data field.
// - unimplemented bits and invalid addresses read as zero.
// - every read fetches its register, clearing clear-on-read registers.
// - default mode changes data out on serial clock falling edges.
// - fast mode changes data out on rising edges; sampling unchanged.
// - the fast-timing bit is written through this port in either mode.
`timescale 1ns/10ps
module ssrp_core
    import ssrp_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // serial pins
    input  wire logic        sck,
    input  wire logic        mosi,
    input  wire logic        port_select_n,
    output logic             misoOut,
    output logic             misoOe,
    // output timing control
    output logic             fastMode,
    // internal register access
    output ssrp_req_t        regReq,
    output logic             regWrStb,
    output logic             regRdStb,
    input  wire logic [31:0] regRdData,
    input  wire logic        regRdHit
);

    // -------------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------------
    logic [2:0]         pinSync;
    logic               sckS;
    logic               mosiS;
    logic               selS;
    logic               sckPrev_q;
    logic               sckRise;
    logic               sckFall;
    logic               selEnd;
    ssrp_state_t        state_q;
    logic               stActive;
    logic [CNT_W-1:0]   rxCount_q;
    logic [INSTR_W-2:0] rxShift_q;
    logic [INSTR_W-1:0] rxWord;
    logic               done;
    logic               curCmd_q;
    logic               seenRise_q;
    logic               outAdv;
    logic [CNT_W-1:0]   outIdx_q;
    logic [HDR_W-1:0]   hdr_q;
    logic [DATA_W-1:0]  dataHold_q;
    logic               fastMode_q;
    logic               txBit;
    logic               misoOut_q;
    logic               misoOe_q;
    logic               outLoad_q;
    ssrp_req_t          regReq_q;
    logic               wrStb_q;
    logic               rdStb_q;
    logic               wordIsWr;
    logic               wordChOk;
    logic               wordFast;

    // -------------------------------------------------------------------------
    // address decode helpers
    // -------------------------------------------------------------------------
    // channel codes 10 and 11 reach no register
    function automatic logic chanValid(input logic [1:0] ch);
        chanValid = (ch == CHAN_0) || (ch == CHAN_1);
    endfunction : chanValid

    // the timing control bit lives at a fixed address of its own
    function automatic logic isFastAddr(input logic [HDR_W-2:0] a);
        isFastAddr = (a[22:21] == FAST_CHAN) && (a[20:16] == FAST_DEV)
                     && (a[15:0] == FAST_REG);
    endfunction : isFastAddr

    // -------------------------------------------------------------------------
    // pin synchronisers and edge detection
    // -------------------------------------------------------------------------
    ssrp_sync #(
        .WIDTH     (3),
        .RESET_VAL (PIN_RST)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   ({sck, mosi, port_select_n}),
        .dout  (pinSync)
    );

    assign sckS  = pinSync[2];
    assign mosiS = pinSync[1];
    assign selS  = ~pinSync[0];

    // previous serial clock level, for edge finding
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sckPrev_q <= 1'h0;
        end else begin
            sckPrev_q <= sckS;
        end
    end

    assign sckRise  = sckS & ~sckPrev_q;
    assign sckFall  = ~sckS & sckPrev_q;
    assign stActive = (state_q == SSRP_ACTIVE);
    assign selEnd   = stActive & ~selS;

    // -------------------------------------------------------------------------
    // select state: edges seen while deselected are dropped
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= SSRP_IDLE;
        end else begin
            unique case (state_q)
                SSRP_IDLE:   if (selS) state_q <= SSRP_ACTIVE;
                SSRP_ACTIVE: if (!selS) state_q <= SSRP_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // receive shifter: 56 rising edges make one instruction
    // -------------------------------------------------------------------------
    assign done   = stActive & selS & sckRise & (rxCount_q == LAST_BIT);
    assign rxWord = {rxShift_q, mosiS};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxCount_q <= '0;
            rxShift_q <= '0;
        end else if (!stActive || !selS) begin
            rxCount_q <= '0;
        end else if (sckRise) begin
            rxShift_q <= {rxShift_q[INSTR_W-3:0], mosiS};
            if (rxCount_q == LAST_BIT) begin
                rxCount_q <= '0;
            end else begin
                rxCount_q <= rxCount_q + 6'h01;
            end
        end
    end

    // command of the instruction now shifting, known after its first edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            curCmd_q <= CMD_READ;
        end else if (stActive && selS && sckRise && rxCount_q == '0) begin
            curCmd_q <= mosiS;
        end
    end

    // -------------------------------------------------------------------------
    // instruction decode
    // -------------------------------------------------------------------------
    assign wordIsWr = (rxWord[CMD_POS] == CMD_WRITE);
    assign wordChOk = chanValid(rxWord[CHAN_HI:CHAN_LO]);
    assign wordFast = isFastAddr(rxWord[CHAN_HI:REG_LO]);

    // echo header: command and address of the last whole instruction
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hdr_q <= '0;
        end else if (done) begin
            hdr_q <= rxWord[INSTR_W-1:DATA_W];
        end
    end

    // request to the register file; reserved channels raise no strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regReq_q <= '0;
            wrStb_q  <= 1'h0;
            rdStb_q  <= 1'h0;
        end else begin
            wrStb_q <= done & wordIsWr & wordChOk & ~wordFast;
            rdStb_q <= done & ~wordIsWr & wordChOk & ~wordFast;
            if (done) begin
                regReq_q.chan <= rxWord[CHAN_HI:CHAN_LO];
                regReq_q.dev  <= rxWord[DEV_HI:DEV_LO];
                regReq_q.num  <= rxWord[REG_HI:REG_LO];
                regReq_q.data <= rxWord[DATA_W-1:0];
            end
        end
    end

    // data for the next instruction's data field
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dataHold_q <= '0;
        end else if (done && wordIsWr) begin
            dataHold_q <= rxWord[DATA_W-1:0];
        end else if (done && wordFast) begin
            dataHold_q <= {{(DATA_W-1){1'b0}}, fastMode_q};
        end else if (done && !wordChOk) begin
            dataHold_q <= '0;
        end else if (rdStb_q) begin
            dataHold_q <= regRdHit ? regRdData : '0;
        end
    end

    // timing control bit, writable in either mode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fastMode_q <= FAST_RST;
        end else if (done && wordIsWr && wordFast) begin
            fastMode_q <= rxWord[FAST_BIT];
        end
    end

    // -------------------------------------------------------------------------
    // output position: advances on the edge that the timing mode names
    // -------------------------------------------------------------------------
    // a falling edge before any rising edge (clock idling high) is no shift
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seenRise_q <= 1'h0;
        end else if (!stActive) begin
            seenRise_q <= 1'h0;
        end else if (sckRise) begin
            seenRise_q <= 1'h1;
        end
    end

    assign outAdv = fastMode_q ? sckRise : (sckFall & seenRise_q);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outIdx_q <= '0;
        end else if (!stActive || !selS) begin
            outIdx_q <= '0;
        end else if (outAdv) begin
            if (outIdx_q == LAST_BIT) begin
                outIdx_q <= '0;
            end else begin
                outIdx_q <= outIdx_q + 6'h01;
            end
        end
    end

    ssrp_tx_mux u_mux (
        .hdr      (hdr_q),
        .dataHold (dataHold_q),
        .curCmd   (curCmd_q),
        .idx      (outIdx_q),
        .txBit    (txBit)
    );

    // registered pin drive; loaded at select and as the position moves, never mid-bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            misoOut_q <= 1'h0;
            misoOe_q  <= 1'h0;
            outLoad_q <= 1'h0;
        end else begin
            misoOe_q  <= stActive & selS;
            outLoad_q <= outAdv;
            misoOut_q <= !(stActive && selS) ? 1'h0
                         : (!misoOe_q || outLoad_q) ? txBit : misoOut_q;
        end
    end

    assign misoOut  = misoOut_q;
    assign misoOe   = misoOe_q;
    assign fastMode = fastMode_q;
    assign regReq   = regReq_q;
    assign regWrStb = wrStb_q;
    assign regRdStb = rdStb_q;

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    logic hdrBitExp;
    logic dataBitExp;
    assign hdrBitExp  = hdr_q[5'(HDR_TOP - outIdx_q[4:0])];
    assign dataBitExp = dataHold_q[5'(LAST_BIT - outIdx_q)];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_float_deselect: assert property (!selS |=> !misoOe)
        else $error("data out driven while deselected");
    a_count_range: assert property (rxCount_q <= LAST_BIT)
        else $error("bit counter past last bit");
    a_sample_rise: assert property ((stActive && selS && sckRise && rxCount_q != LAST_BIT)
        |=> rxCount_q == $past(rxCount_q) + 6'h01)
        else $error("rising edge not counted");
    a_write_strobe: assert property ((done && wordIsWr && wordChOk && !wordFast)
        |=> regWrStb && regReq.data == $past(rxWord[DATA_W-1:0]))
        else $error("write not passed to register file");
    a_read_fetch: assert property ((done && !wordIsWr && wordChOk && !wordFast)
        |=> regRdStb ##1 dataHold_q == ($past(regRdHit) ? $past(regRdData) : 32'h0))
        else $error("read fetch missing or not held");
    a_reserved_chan: assert property ((regWrStb || regRdStb) |-> !regReq.chan[1])
        else $error("strobe for reserved channel");
    a_echo_header: assert property ((stActive && selS && outIdx_q < HDR_END)
        |=> misoOut == $past(hdrBitExp))
        else $error("header echo wrong");
    a_echo_write: assert property ((outLoad_q && stActive && selS && outIdx_q >= HDR_END
        && hdr_q[HDR_W-1]) |=> misoOut == $past(dataBitExp))
        else $error("write data echo wrong");
    a_zero_after_read: assert property ((stActive && selS && outIdx_q >= HDR_END
        && !hdr_q[HDR_W-1] && curCmd_q) |=> !misoOut)
        else $error("data field not zero for write after read");
    a_out_edge: assert property ((stActive && selS && !outAdv) |=> $stable(outIdx_q))
        else $error("output moved on the wrong edge");
    a_out_hold: assert property ((stActive && selS && misoOe && !outLoad_q) |=> $stable(misoOut))
        else $error("data out changed between shifts");
    a_partial_drop: assert property (selEnd |=> rxCount_q == '0 && outIdx_q == '0)
        else $error("partial instruction kept");
    a_fast_write: assert property ((done && wordIsWr && wordFast)
        |=> fastMode == $past(rxWord[FAST_BIT]))
        else $error("timing bit not updated");

    c_write_done: cover property (regWrStb);
    c_read_done: cover property (regRdStb);
    c_partial_drop: cover property (selEnd && rxCount_q != '0);
    c_fast_on: cover property (!fastMode ##1 fastMode);

endmodule : ssrp_core

// File: ssrp_master_model.sv
// ssrp_master_model: behavioural serial master that shifts whole instructions
`timescale 1ns/10ps
module ssrp_master_model
    import ssrp_pkg::*;
(
    // bench clock, all pin moves land on its falling edge
    input  wire logic clk,
    // serial pins
    output logic      sck,
    output logic      mosi,
    output logic      port_select_n,
    input  wire logic misoWire
);
    // -------------------------------------------------------------------------
    // idle levels: clock stands low outside frames, select high
    // -------------------------------------------------------------------------
    initial begin
        sck           = 1'b0;
        mosi          = 1'b0;
        port_select_n = 1'b1;
    end

    // half bit of 400 ns gives the 800 ns link period
    task automatic halfBit();
        repeat (4) @(negedge clk);
    endtask : halfBit

    // shift nBits of tx msb first; fewer than 56 aborts the instruction
    task automatic xfer(input logic fast, input int nBits, input logic [INSTR_W-1:0] tx,
                        output logic [INSTR_W-1:0] rx);
        rx = '0;
        @(negedge clk);
        port_select_n = 1'b0;
        halfBit();
        halfBit();                       // select settles before the first edge
        for (int i = 0; i < nBits; i++) begin
            mosi = tx[CMD_POS-i];
            halfBit();
            if (fast)
                rx[CMD_POS-i] = misoWire;
            sck = 1'b1;
            halfBit();
            if (!fast)
                rx[CMD_POS-i] = misoWire;
            sck = 1'b0;
        end
        halfBit();
        port_select_n = 1'b1;
        mosi          = ~mosi;           // released line must not look stable
        repeat (8) @(negedge clk);       // gap long enough for the sync to see it
    endtask : xfer
endmodule : ssrp_master_model

// File: tb_top.sv
// tb_top: self-checking bench of the serial register port
`timescale 1ns/10ps
module tb_top
    import ssrp_pkg::*;
;
    // -------------------------------------------------------------------------
    // addresses and data used by the scenarios
    // -------------------------------------------------------------------------
    localparam logic [22:0] ADDR_A  = {2'h1, 5'h03, 16'h0010};
    localparam logic [22:0] ADDR_C  = {2'h0, 5'h1E, 16'h0040};
    localparam logic [22:0] ADDR_M  = {2'h0, 5'h04, 16'h0BAD};
    localparam logic [22:0] ADDR_F  = {FAST_CHAN, FAST_DEV, FAST_REG};
    localparam logic [22:0] ADDR_R2 = {2'h2, 5'h03, 16'h0010};
    localparam logic [22:0] ADDR_R3 = {2'h3, 5'h03, 16'h0010};
    localparam logic [31:0] D1      = 32'hA1B2C3D4;
    localparam logic [31:0] D2      = 32'h0F1E2D3C;
    localparam logic [31:0] D3      = 32'h87654321;
    localparam logic [31:0] JUNK    = 32'hFFFFFFFF;
    localparam int          TMO_CYC = 20000;

    logic        clk, rst_b, sck, mosi, port_select_n;
    logic        misoOut, misoOe, fastMode, regWrStb, regRdStb, regRdHit;
    wire         misoWire;
    ssrp_req_t   regReq;
    logic [31:0] regRdData, regA_q, corReg_q;
    logic [22:0] reqAddr;
    int          n_errors, checks, nWr, cycles;

    // -------------------------------------------------------------------------
    // clock, pin resolution and instances
    // -------------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    assign misoWire = misoOe ? misoOut : 1'bz;  // floats while not driven

    ssrp_core i_ssrp_core (.clk(clk), .rst_b(rst_b), .sck(sck), .mosi(mosi),
        .port_select_n(port_select_n), .misoOut(misoOut), .misoOe(misoOe),
        .fastMode(fastMode), .regReq(regReq), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .regRdHit(regRdHit));

    ssrp_master_model i_ssrp_master_model (.clk(clk), .sck(sck), .mosi(mosi),
        .port_select_n(port_select_n), .misoWire(misoWire));

    // -------------------------------------------------------------------------
    // small register file: one plain register, one clear-on-read register
    // -------------------------------------------------------------------------
    assign reqAddr   = {regReq.chan, regReq.dev, regReq.num};
    assign regRdHit  = (reqAddr == ADDR_A) || (reqAddr == ADDR_C);
    // a miss shows junk so that missing zero forcing is caught
    assign regRdData = (reqAddr == ADDR_A) ? regA_q : (reqAddr == ADDR_C) ? corReg_q : JUNK;

    always @(posedge clk) begin
        if (regWrStb)
            nWr <= nWr + 1;
        if (regWrStb && reqAddr == ADDR_A)
            regA_q <= regReq.data;
        if (regRdStb && reqAddr == ADDR_C)
            corReg_q <= 32'h0;
    end

    // -------------------------------------------------------------------------
    // compare, transfer and closing tasks
    // -------------------------------------------------------------------------
    task automatic chk_word(input logic [55:0] got, input logic [55:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // one full instruction, echo compared against exp
    task automatic run(input logic fast, input logic cmd, input logic [22:0] addr,
                       input logic [31:0] data, input logic [55:0] exp);
        logic [55:0] rx;
        i_ssrp_master_model.xfer(fast, INSTR_W, {cmd, addr, data}, rx);
        chk_word(rx, exp);
    endtask : run

    task automatic end_sim();
        if (n_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // -------------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------------
    // write, pipelined reads, clear-on-read fetch, write after read
    task automatic t_basic();
        corReg_q = 32'h00C0FFEE;
        run(1'b0, CMD_WRITE, ADDR_A, D1, 56'h0);
        chk_word(56'(regA_q), 56'(D1));
        run(1'b0, CMD_READ, ADDR_A, JUNK, {1'b1, ADDR_A, D1});
        run(1'b0, CMD_READ, ADDR_C, JUNK, {1'b0, ADDR_A, D1});
        chk_word(56'(regA_q), 56'(D1));
        run(1'b0, CMD_READ, ADDR_A, D2, {1'b0, ADDR_C, 32'h00C0FFEE});
        chk_word(56'(corReg_q), 56'h0);
        run(1'b0, CMD_WRITE, ADDR_A, D2, {1'b0, ADDR_A, 32'h0});
        run(1'b0, CMD_READ, ADDR_A, JUNK, {1'b1, ADDR_A, D2});
        chk_bit(misoWire, 1'bz);
    endtask : t_basic

    // reserved channels, invalid address, aborted instruction
    task automatic t_refuse();
        int          n0;
        logic [55:0] rx;
        n0 = nWr;
        run(1'b0, CMD_WRITE, ADDR_R2, D3, {1'b0, ADDR_A, 32'h0});
        chk_bit(nWr == n0, 1'b1);
        run(1'b0, CMD_READ, ADDR_R3, JUNK, {1'b1, ADDR_R2, D3});
        run(1'b0, CMD_READ, ADDR_M, JUNK, {1'b0, ADDR_R3, 32'h0});
        i_ssrp_master_model.xfer(1'b0, 20, {CMD_WRITE, ADDR_A, D1}, rx);
        chk_bit(nWr == n0, 1'b1);
        run(1'b0, CMD_READ, ADDR_A, JUNK, {1'b0, ADDR_M, 32'h0});
        chk_word(56'(regA_q), 56'(D2));
    endtask : t_refuse

    // switch to rising-edge output and back through the port itself
    task automatic t_fast();
        run(1'b0, CMD_WRITE, ADDR_F, 32'h1, {1'b0, ADDR_A, 32'h0});
        chk_bit(fastMode, 1'b1);
        run(1'b1, CMD_READ, ADDR_A, JUNK, {1'b1, ADDR_F, 32'h1});
        run(1'b1, CMD_READ, ADDR_F, JUNK, {1'b0, ADDR_A, D2});
        run(1'b1, CMD_READ, ADDR_A, JUNK, {1'b0, ADDR_F, 32'h1});
        run(1'b1, CMD_WRITE, ADDR_F, 32'h0, {1'b0, ADDR_A, 32'h0});
        chk_bit(fastMode, 1'b0);
        run(1'b0, CMD_READ, ADDR_A, JUNK, {1'b1, ADDR_F, 32'h0});
    endtask : t_fast

    // -------------------------------------------------------------------------
    // hang guard and main sequence
    // -------------------------------------------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == TMO_CYC) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        rst_b    = 1'b0;
        regA_q   = 32'h0;
        corReg_q = 32'h0;
        n_errors = 0;
        checks   = 0;
        nWr      = 0;
        cycles   = 0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk_bit(fastMode, FAST_RST);
        t_basic();
        t_refuse();
        t_fast();
        end_sim();
    end
endmodule : tb_top
